// File: design/sle_map.svh
`ifndef SLE_MAP_SVH
`define SLE_MAP_SVH

// Clock and pattern timing
`define SLE_CLK_MHZ 20
`define SLE_TICK_US 1000
`define SLE_TICK_CYCLES (`SLE_TICK_US * `SLE_CLK_MHZ)
`define SLE_FLICK_HALF_MS 50
`define SLE_BLINK_HALF_MS 200
`define SLE_DBL_GAP_MS 1000
`define SLE_DBL_PERIOD_MS (3 * `SLE_BLINK_HALF_MS + `SLE_DBL_GAP_MS)
`define SLE_FPD_LATENCY_MS 15

// Register offsets
`define SLE_OFF_CTRL 8'h00
`define SLE_OFF_COND 8'h04
`define SLE_OFF_LAMP 8'h08
`define SLE_OFF_INT_STS 8'h0c
`define SLE_OFF_INT_MASK 8'h10

// Field positions
`define SLE_CTRL_LAMP_TEST 0
`define SLE_LAMP_RUN_PAT_LSB 0
`define SLE_LAMP_FLT_PAT_LSB 4
`define SLE_LAMP_RUN_BIT 8
`define SLE_LAMP_FLT_BIT 9
`define SLE_LAMP_MODE_LSB 12

// Interrupt event bits
`define SLE_EV_POWER_LOST 0
`define SLE_EV_WDOG 1
`define SLE_EV_FIELD 2
`define SLE_EV_OVERCUR 3
`define SLE_EV_NONFATAL 4
`define SLE_EV_BUS_STOP 5
`define SLE_EV_W 6

// Reset values
`define SLE_CTRL_RST 1'h0
`define SLE_INT_MASK_RST 6'h00
`define SLE_EV_PREV_RST 6'h01

`endif

// File: design/sle_pkg.sv
package sle_pkg;

    typedef enum logic [2:0] {
        SLE_PAT_OFF,
        SLE_PAT_ON,
        SLE_PAT_FLICKER,
        SLE_PAT_BLINK1,
        SLE_PAT_BLINK2
    } sle_pat_e;

    typedef enum logic [1:0] {
        SLE_MODE_DARK,
        SLE_MODE_WDOG,
        SLE_MODE_ADDR,
        SLE_MODE_RUN
    } sle_mode_e;

endpackage : sle_pkg

// File: design/sle_encoder.sv
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "sle_map.svh"

module sle_encoder #(
    parameter int TICK_CYCLES = `SLE_TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Condition pins
    input wire logic logic_power_ok,
    input wire logic module_failed,
    input wire logic auto_addr_busy,
    input wire logic wdog_expired,
    input wire logic operational,
    input wire logic pre_operational,
    input wire logic over_current,
    input wire logic broken_wire,
    input wire logic field_power_absent,
    input wire logic field_power_distributor_fault,
    input wire logic nonfatal_error,
    input wire logic bus_stopped,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Lamps and interrupt
    output logic run_lamp,
    output logic fault_lamp,
    output logic irq
);

    localparam int NCOND = 12;
    localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam int MSW = 11;

    generate
        if (TICK_CYCLES < 1)
        begin : g_bad_tick
            $error("TICK_CYCLES must be at least 1");
        end
        if (`SLE_DBL_PERIOD_MS % (2 * `SLE_BLINK_HALF_MS) != 0)
        begin : g_bad_period
            $error("Double blink period must hold whole single blinks");
        end
    endgenerate

    // Condition synchronisers
    wire logic [NCOND-1:0] cond_raw;
    logic [NCOND-1:0] sync1_q;
    logic [NCOND-1:0] cond_q;

    assign cond_raw = {bus_stopped, nonfatal_error, field_power_distributor_fault,
                       field_power_absent, broken_wire, over_current, pre_operational,
                       operational, wdog_expired, auto_addr_busy, module_failed,
                       logic_power_ok};

    genvar gi;
    generate
        for (gi = 0; gi < NCOND; gi++)
        begin : g_sync
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    sync1_q[gi] <= 1'b0;
                    cond_q[gi] <= 1'b0;
                end
                else if (ce)
                begin
                    sync1_q[gi] <= cond_raw[gi];
                    cond_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    wire logic powered;
    wire logic s_wdog;
    wire logic s_addr;
    wire logic s_oper;
    wire logic s_preop;
    wire logic s_overcur;
    wire logic s_field;
    wire logic s_nonfatal;
    wire logic s_bus_stop;

    assign powered = cond_q[0] && !cond_q[1];
    assign s_addr = cond_q[2];
    assign s_wdog = cond_q[3];
    assign s_oper = cond_q[4];
    assign s_preop = cond_q[5];
    assign s_overcur = cond_q[6];
    // Distributor faults come late from outside; local ones go straight through
    assign s_field = cond_q[7] || cond_q[8] || cond_q[9];
    assign s_nonfatal = cond_q[10];
    assign s_bus_stop = cond_q[11];

    // Millisecond time base, free running so all lamps stay in step
    logic [TW-1:0] tick_cnt_q;
    logic [MSW-1:0] ms_cnt_q;
    wire logic ms_tick;
    wire logic ms_wrap;

    assign ms_tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));
    assign ms_wrap = (ms_cnt_q == MSW'(`SLE_DBL_PERIOD_MS - 1));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_q <= '0;
            ms_cnt_q <= '0;
        end
        else if (ce)
        begin
            tick_cnt_q <= ms_tick ? '0 : tick_cnt_q + TW'(1);
            if (ms_tick)
                ms_cnt_q <= ms_wrap ? '0 : ms_cnt_q + MSW'(1);
        end
    end

    wire logic flick_on;
    wire logic blink_on;
    wire logic dbl_on;

    assign flick_on = (ms_cnt_q % (2 * `SLE_FLICK_HALF_MS)) < `SLE_FLICK_HALF_MS;
    assign blink_on = (ms_cnt_q % (2 * `SLE_BLINK_HALF_MS)) < `SLE_BLINK_HALF_MS;
    // Two pulses, then a long gap
    assign dbl_on = (ms_cnt_q < 3 * `SLE_BLINK_HALF_MS) && blink_on;

    function automatic logic lamp_of(input sle_pkg::sle_pat_e pat, input logic fl,
                                     input logic b1, input logic b2);
        case (pat)
            sle_pkg::SLE_PAT_ON: lamp_of = 1'b1;
            sle_pkg::SLE_PAT_FLICKER: lamp_of = fl;
            sle_pkg::SLE_PAT_BLINK1: lamp_of = b1;
            sle_pkg::SLE_PAT_BLINK2: lamp_of = b2;
            default: lamp_of = 1'b0;
        endcase
    endfunction : lamp_of

    // Mode and pattern decode
    sle_pkg::sle_mode_e mode;
    sle_pkg::sle_pat_e run_pat;
    sle_pkg::sle_pat_e fault_pat;

    assign mode = !powered ? sle_pkg::SLE_MODE_DARK :
                  s_wdog ? sle_pkg::SLE_MODE_WDOG :
                  s_addr ? sle_pkg::SLE_MODE_ADDR :
                  sle_pkg::SLE_MODE_RUN;

    always_comb
    begin
        run_pat = sle_pkg::SLE_PAT_OFF;
        fault_pat = sle_pkg::SLE_PAT_OFF;
        case (mode)
            sle_pkg::SLE_MODE_DARK:
            begin
                run_pat = sle_pkg::SLE_PAT_OFF;
                fault_pat = sle_pkg::SLE_PAT_OFF;
            end
            sle_pkg::SLE_MODE_WDOG:
            begin
                run_pat = sle_pkg::SLE_PAT_ON;
                fault_pat = sle_pkg::SLE_PAT_ON;
            end
            sle_pkg::SLE_MODE_ADDR:
            begin
                run_pat = sle_pkg::SLE_PAT_FLICKER;
                fault_pat = sle_pkg::SLE_PAT_OFF;
            end
            sle_pkg::SLE_MODE_RUN:
            begin
                // Each lamp decided on its own when a condition leaves it open
                if (s_overcur)
                    run_pat = sle_pkg::SLE_PAT_ON;
                else if (s_preop)
                    run_pat = sle_pkg::SLE_PAT_BLINK1;
                else if (s_oper)
                    run_pat = sle_pkg::SLE_PAT_ON;
                else
                    run_pat = sle_pkg::SLE_PAT_OFF;
                if (s_field || s_overcur)
                    fault_pat = sle_pkg::SLE_PAT_FLICKER;
                else if (s_bus_stop)
                    fault_pat = sle_pkg::SLE_PAT_BLINK2;
                else if (s_nonfatal)
                    fault_pat = sle_pkg::SLE_PAT_BLINK1;
                else
                    fault_pat = sle_pkg::SLE_PAT_OFF;
            end
            default:
            begin
                run_pat = sle_pkg::SLE_PAT_OFF;
                fault_pat = sle_pkg::SLE_PAT_OFF;
            end
        endcase
    end

    // Lamp outputs
    logic ctrl_test_q;
    logic run_lamp_q;
    logic fault_lamp_q;
    wire logic run_lamp_d;
    wire logic fault_lamp_d;

    // Lamp test cannot light a module that has no power
    assign run_lamp_d = powered && (ctrl_test_q || lamp_of(run_pat, flick_on, blink_on, dbl_on));
    assign fault_lamp_d = powered &&
                          (ctrl_test_q || lamp_of(fault_pat, flick_on, blink_on, dbl_on));

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            run_lamp_q <= 1'b0;
            fault_lamp_q <= 1'b0;
        end
        else if (ce)
        begin
            run_lamp_q <= run_lamp_d;
            fault_lamp_q <= fault_lamp_d;
        end
    end

    assign run_lamp = run_lamp_q;
    assign fault_lamp = fault_lamp_q;

    // Interrupt events
    logic [`SLE_EV_W-1:0] ev_prev_q;
    logic [`SLE_EV_W-1:0] int_sts_q;
    logic [`SLE_EV_W-1:0] int_mask_q;
    wire logic [`SLE_EV_W-1:0] ev_level;
    wire logic [`SLE_EV_W-1:0] ev_set;
    wire logic [`SLE_EV_W-1:0] ev_clr;

    assign ev_level = {s_bus_stop, s_nonfatal, s_overcur, s_field, s_wdog, !powered};
    assign ev_set = ev_level & ~ev_prev_q;

    // Register decode
    wire logic hit_ctrl;
    wire logic hit_cond;
    wire logic hit_lamp;
    wire logic hit_sts;
    wire logic hit_mask;
    wire logic [31:0] rd_mux;

    assign hit_ctrl = (reg_addr == `SLE_OFF_CTRL);
    assign hit_cond = (reg_addr == `SLE_OFF_COND);
    assign hit_lamp = (reg_addr == `SLE_OFF_LAMP);
    assign hit_sts = (reg_addr == `SLE_OFF_INT_STS);
    assign hit_mask = (reg_addr == `SLE_OFF_INT_MASK);
    assign ev_clr = (reg_wr && hit_sts) ? reg_wdata[`SLE_EV_W-1:0] : '0;

    assign rd_mux = hit_ctrl ? {31'h0, ctrl_test_q} :
                    hit_cond ? {20'h0, cond_q} :
                    hit_lamp ? {18'h0, mode, 2'h0, fault_lamp_q, run_lamp_q,
                                1'b0, fault_pat, 1'b0, run_pat} :
                    hit_sts ? {26'h0, int_sts_q} :
                    hit_mask ? {26'h0, int_mask_q} :
                    32'h0;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            // Unpowered in reset, so release raises no false power-lost event
            ev_prev_q <= `SLE_EV_PREV_RST;
            int_sts_q <= '0;
        end
        else if (ce)
        begin
            ev_prev_q <= ev_level;
            // Set wins over a clear in the same cycle
            int_sts_q <= (int_sts_q & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_test_q <= `SLE_CTRL_RST;
            int_mask_q <= `SLE_INT_MASK_RST;
        end
        else if (ce && reg_wr)
        begin
            if (hit_ctrl)
                ctrl_test_q <= reg_wdata[`SLE_CTRL_LAMP_TEST];
            if (hit_mask)
                int_mask_q <= reg_wdata[`SLE_EV_W-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0;
        else if (ce)
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end

    assign irq = |(int_sts_q & int_mask_q);

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_dark_no_power: assert property (
        (ce && !powered) |=> (!run_lamp && !fault_lamp))
        else $error("lamps lit without power");

    a_addr_flicker: assert property (
        (mode == sle_pkg::SLE_MODE_ADDR) |->
            (run_pat == sle_pkg::SLE_PAT_FLICKER && fault_pat == sle_pkg::SLE_PAT_OFF))
        else $error("addressing pattern wrong");

    a_wdog_both_on: assert property (
        (ce && powered && s_wdog) |=> (run_lamp && fault_lamp))
        else $error("watchdog lamps not both on");

    a_oper_run_on: assert property (
        (ce && mode == sle_pkg::SLE_MODE_RUN && s_oper && !s_preop && !s_overcur
         && !s_field && !s_bus_stop && !s_nonfatal && !ctrl_test_q)
            |=> (run_lamp && !fault_lamp))
        else $error("operational lamps wrong");

    a_overcur_pattern: assert property (
        (mode == sle_pkg::SLE_MODE_RUN && s_overcur) |->
            (run_pat == sle_pkg::SLE_PAT_ON && fault_pat == sle_pkg::SLE_PAT_FLICKER))
        else $error("over-current pattern wrong");

    a_field_flicker: assert property (
        (mode == sle_pkg::SLE_MODE_RUN && $rose(cond_q[7])) |->
            (fault_pat == sle_pkg::SLE_PAT_FLICKER))
        else $error("field fault not flickering");

    a_preop_blink: assert property (
        (mode == sle_pkg::SLE_MODE_RUN && s_preop && !s_overcur) |->
            (run_pat == sle_pkg::SLE_PAT_BLINK1))
        else $error("pre-operational blink missing");

    a_nonfatal_blink: assert property (
        (mode == sle_pkg::SLE_MODE_RUN && s_nonfatal && !s_field && !s_overcur
         && !s_bus_stop) |-> (fault_pat == sle_pkg::SLE_PAT_BLINK1))
        else $error("nonfatal blink missing");

    a_bus_blink2: assert property (
        (mode == sle_pkg::SLE_MODE_RUN && s_bus_stop && !s_field && !s_overcur) |->
            (fault_pat == sle_pkg::SLE_PAT_BLINK2))
        else $error("bus stopped blink missing");

    a_flicker_half: assert property (
        (ce && ms_tick && ms_cnt_q == MSW'(`SLE_FLICK_HALF_MS - 1)) |=> !flick_on ##0
            (ms_cnt_q == MSW'(`SLE_FLICK_HALF_MS)))
        else $error("flicker half period wrong");

    a_blink_half: assert property (
        (ce && ms_tick && ms_cnt_q == MSW'(`SLE_BLINK_HALF_MS - 1)) |=> !blink_on)
        else $error("blink half period wrong");

    a_double_gap: assert property (
        (ms_cnt_q >= MSW'(3 * `SLE_BLINK_HALF_MS)) |-> (!dbl_on && ms_cnt_q <=
            MSW'(`SLE_DBL_PERIOD_MS - 1)))
        else $error("double blink gap wrong");

endmodule : sle_encoder
`default_nettype wire

// File: test/sle_lamp_model.sv
`timescale 1ns/1ns
`default_nettype none

// Front-panel lamp: times its lit and dark spells in clock cycles
module sle_lamp_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clr,
    // Lamp drive and measured spells
    input wire logic lamp,
    output logic [15:0] on_len,
    output logic [15:0] min_off,
    output logic [15:0] max_off
);
    logic [15:0] cnt_q;
    logic prev_q;
    logic seen_q;

    // First spell after a clear is partial, so it is dropped
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
            prev_q <= 1'b0;
            on_len <= 16'h0000;
            min_off <= 16'hffff;
            max_off <= 16'h0000;
        end
        else if (clr)
        begin
            cnt_q <= 16'h0000;
            seen_q <= 1'b0;
            prev_q <= lamp;
            on_len <= 16'h0000;
            min_off <= 16'hffff;
            max_off <= 16'h0000;
        end
        else
        begin
            prev_q <= lamp;
            if (lamp != prev_q)
            begin
                cnt_q <= 16'h0001;
                seen_q <= 1'b1;
                if (seen_q && prev_q)
                    on_len <= cnt_q;
                if (seen_q && !prev_q && cnt_q < min_off)
                    min_off <= cnt_q;
                if (seen_q && !prev_q && cnt_q > max_off)
                    max_off <= cnt_q;
            end
            else
                cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : sle_lamp_model

`default_nettype wire

// File: test/sle_encoder_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "sle_map.svh"

module sle_encoder_bench;
    localparam int TICK = 4;
    localparam int LIMIT = 40000;
    localparam logic [2:0] OF = sle_pkg::SLE_PAT_OFF;
    localparam logic [2:0] ON = sle_pkg::SLE_PAT_ON;
    localparam logic [2:0] FL = sle_pkg::SLE_PAT_FLICKER;
    localparam logic [2:0] B1 = sle_pkg::SLE_PAT_BLINK1;
    localparam logic [2:0] B2 = sle_pkg::SLE_PAT_BLINK2;
    // Condition bits, then run and fault pattern
    localparam logic [17:0] ROWS [14] = '{
        {12'h000, OF, OF},
        {12'h003, OF, OF},
        {12'h005, FL, OF},
        {12'h049, ON, ON},
        {12'h011, ON, OF},
        {12'h051, ON, FL},
        {12'h081, OF, FL},
        {12'h101, OF, FL},
        {12'h201, OF, FL},
        {12'h021, B1, OF},
        {12'h411, ON, B1},
        {12'h811, ON, B2},
        {12'h0a1, B1, FL},
        {12'h00b, OF, OF}
    };
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic clr = 1'b0;
    logic [11:0] cond = 12'h000;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic run_lamp;
    logic fault_lamp;
    logic irq;
    logic [15:0] run_on, run_min, run_max, flt_on, flt_min, flt_max;
    logic [31:0] rd;
    logic [17:0] row;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;

    initial
    begin
        forever #25 ref_clk = ~ref_clk;
    end

    sle_encoder #(.TICK_CYCLES(TICK)) dut (
        .ref_clk(ref_clk), .rst(rst), .ce(ce),
        .logic_power_ok(cond[0]), .module_failed(cond[1]), .auto_addr_busy(cond[2]),
        .wdog_expired(cond[3]), .operational(cond[4]), .pre_operational(cond[5]),
        .over_current(cond[6]), .broken_wire(cond[7]), .field_power_absent(cond[8]),
        .field_power_distributor_fault(cond[9]), .nonfatal_error(cond[10]),
        .bus_stopped(cond[11]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .run_lamp(run_lamp), .fault_lamp(fault_lamp), .irq(irq)
    );
    sle_lamp_model run_model (.ref_clk(ref_clk), .rst(rst), .clr(clr), .lamp(run_lamp),
        .on_len(run_on), .min_off(run_min), .max_off(run_max));
    sle_lamp_model flt_model (.ref_clk(ref_clk), .rst(rst), .clr(clr), .lamp(fault_lamp),
        .on_len(flt_on), .min_off(flt_min), .max_off(flt_max));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_val

    task automatic chk_len(input logic [15:0] got, input int exp, input string msg);
        checks_done++;
        if (got !== 16'(exp))
        begin
            fails++;
            $display("CHECK FAILED at %0t: %s spell %0d exp %0d", $time, msg, got, exp);
        end
    endtask : chk_len

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : reg_read

    // Apply conditions, let the lamps follow, then clear the lamp models
    // Clearing only after the switch keeps a cut spell out of the measurements
    task automatic settle(input logic [11:0] c, input int n);
        @(posedge ref_clk);
        cond <= c;
        repeat (4) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : settle

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // Hang guard: generous against the longest double-blink wait
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            $display("CHECK FAILED at %0t: run did not complete", $time);
            finish_test();
        end
    end

    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (ROWS[i])
        begin
            row = ROWS[i];
            settle(row[17:6], 6);
            if (row[5:3] inside {OF, ON})
                chk_val(32'(run_lamp), 32'(row[5:3] == ON), "run lamp");
            if (row[2:0] inside {OF, ON})
                chk_val(32'(fault_lamp), 32'(row[2:0] == ON), "fault lamp");
            reg_read(`SLE_OFF_LAMP, rd);
            chk_val({26'h0, rd[6:4], rd[2:0]}, {26'h0, row[2:0], row[5:3]}, "patterns");
        end
        $display("condition table done");
        settle(12'h005, 1200);
        chk_len(run_on, 50 * TICK, "flicker on");
        chk_len(run_min, 50 * TICK, "flicker off");
        chk_len(run_max, 50 * TICK, "flicker off max");
        settle(12'h021, 3400);
        chk_len(run_on, 200 * TICK, "blink on");
        chk_len(run_min, 200 * TICK, "blink off");
        chk_len(run_max, 200 * TICK, "blink off max");
        settle(12'h811, 14000);
        chk_len(flt_on, 200 * TICK, "double on");
        chk_len(flt_min, 200 * TICK, "double short off");
        chk_len(flt_max, 1000 * TICK, "double gap");
        $display("pattern timing done");
        settle(12'h001, 6);
        reg_write(`SLE_OFF_CTRL, 32'h00000001);
        repeat (2) @(negedge ref_clk);
        chk_val(32'({run_lamp, fault_lamp}), 32'h00000003, "lamp test on");
        settle(12'h000, 6);
        chk_val(32'({run_lamp, fault_lamp}), 32'h00000000, "lamp test unpowered");
        reg_write(`SLE_OFF_CTRL, 32'h00000000);
        settle(12'h001, 6);
        reg_write(`SLE_OFF_INT_MASK, 32'h00000000);
        reg_write(`SLE_OFF_INT_STS, 32'h0000003f);
        settle(12'h009, 6);
        reg_read(`SLE_OFF_INT_STS, rd);
        chk_val(rd, 32'h00000002, "watchdog event");
        chk_val(32'(irq), 32'h0, "masked irq");
        reg_write(`SLE_OFF_INT_MASK, 32'h00000002);
        @(negedge ref_clk);
        chk_val(32'(irq), 32'h1, "unmasked irq");
        reg_write(`SLE_OFF_INT_STS, 32'h00000002);
        @(negedge ref_clk);
        chk_val(32'(irq), 32'h0, "cleared irq");
        reg_read(8'h40, rd);
        chk_val(rd, 32'h00000000, "unmapped read");
        @(posedge ref_clk);
        ce <= 1'b0;
        reg_write(`SLE_OFF_CTRL, 32'h00000001);
        ce <= 1'b1;
        reg_read(`SLE_OFF_CTRL, rd);
        chk_val(rd, 32'h00000000, "write while frozen");
        $display("registers and interrupt done");
        @(posedge ref_clk);
        rst <= 1'b1;
        @(negedge ref_clk);
        chk_val({29'h0, run_lamp, fault_lamp, irq}, 32'h0, "outputs in reset");
        @(posedge ref_clk);
        rst <= 1'b0;
        reg_read(`SLE_OFF_INT_MASK, rd);
        chk_val(rd, 32'h00000000, "mask after reset");
        reg_read(`SLE_OFF_INT_STS, rd);
        chk_val(rd, 32'h00000002, "events after reset");
        $display("reset done");
        finish_test();
    end
endmodule : sle_encoder_bench

`default_nettype wire
